/* design/test_strap_pkg.sv */
// package: constants, types and register map for the test strap and mode control block
package test_strap_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned PLL_SETTLE_MS    = 60;
    localparam int unsigned PLL_SETTLE_CYC   = (CLK_HZ / 1000) * PLL_SETTLE_MS;

    // ----------------------------------------------------------------
    // strap capture values
    // ----------------------------------------------------------------
    localparam int unsigned TP_WIDTH         = 8;
    localparam int unsigned MODE_BITS        = 4;
    localparam logic [3:0]  MODE_IDLE        = 4'h0;
    localparam logic [3:0]  MODE_CPU_DEBUG   = 4'h1;
    localparam logic [3:0]  MODE_CALIBRATION = 4'h8;
    localparam logic [7:0]  TP_RESET_VALUE   = 8'h00;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0]  MODE_CTRL_ADDR   = 8'h00;
    localparam logic [7:0]  STATUS_ADDR      = 8'h04;
    localparam logic [7:0]  STRAP_ADDR       = 8'h08;
    localparam int unsigned CTRL_ACTIVE_BIT  = 0;
    localparam int unsigned ST_FUNC_BIT      = 0;
    localparam int unsigned ST_CPU_RUN_BIT   = 1;
    localparam int unsigned ST_PLL_RUN_BIT   = 2;
    localparam int unsigned ST_FLOAT_BIT     = 3;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SEQ_HOLD   = 3'b001,
        SEQ_SETTLE = 3'b010,
        SEQ_RUN    = 3'b100
    } seq_state_type;

    typedef struct packed
    {
        logic       vsync;
        logic       wheel_index_dly;
        logic       seq_index;
        logic       wheel_spoke;
        logic       wheel_rev;
        logic [2:0] reset_aux;
    } calib_type;

    typedef struct packed
    {
        logic       pll_reset_n;
        logic       cpu_reset_n;
        logic       active_mode;
        logic       mirror_park;
        logic       display_enable;
    } sys_ctrl_type;

endpackage

/* design/sync_two_flop.sv */
// module: two flip-flop synchroniser for inputs arriving from outside the clock domain
`timescale 1ns/1ns
module sync_two_flop #(
    parameter int unsigned WIDTH = 1
)
(
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             resetn_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            meta_reg <= '0;
            sync_o   <= '0;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end

endmodule // sync_two_flop

/* design/test_strap_ctrl.sv */
// module: test point strap capture, test output mux, board test float and functional mode control
`timescale 1ns/1ns
// How it works
// R1: test points input in reset, driven after
// R2: straps captured at reset release, held
// R3: internal pull-down makes unstrapped pins zero
// R4: default zero capture drives all outputs low
// R5: sampling only on power-sense rising edge
// R6: low four captured bits select test mode
// R7: mode 8 outputs calibration signals in order
// R8: mode 1 routes debug bits; mode 0 zero
// R9: board pull-ups only on bits three to zero
// R10: float enable tristates all but scan outputs
// R11: scan cells on digital I/O, listed exceptions
// R12: standby and active chosen by host command
// R13: standby: cpu only, mirrors parked, no image
// R14: active: everything enabled, video projected
// R15: pll released, rest held 60 ms more
// R16: undefined capture values drive outputs low
module test_strap_ctrl #(
    parameter int unsigned SETTLE_CYCLES = test_strap_pkg::PLL_SETTLE_CYC
)
(
    // clock and reset
    input  wire logic                            mclk_i,
    input  wire logic                            resetn_i,
    // power sense and board test
    input  wire logic                            power_on_sense_i,
    input  wire logic                            incircuit_float_enable_i,
    // test point pins
    input  wire logic [test_strap_pkg::TP_WIDTH-1:0] test_point_port_i,
    output logic      [test_strap_pkg::TP_WIDTH-1:0] test_point_port_o,
    output logic      [test_strap_pkg::TP_WIDTH-1:0] test_point_port_oe_o,
    // scan outputs, floated only while resetn_i is low
    input  wire logic                            scan_tdo_one_i,
    input  wire logic                            scan_tdo_two_i,
    output logic                                 scan_out_one_o,
    output logic                                 scan_out_two_o,
    output logic                                 scan_out_one_oe_o,
    output logic                                 scan_out_two_oe_o,
    // internal sources
    input  wire test_strap_pkg::calib_type       calib_i,
    input  wire logic [7:0]                      cpu_debug_bit_i,
    // system control
    output test_strap_pkg::sys_ctrl_type         sys_ctrl_o,
    output logic                                 outputs_float_o,
    // ahb-lite slave
    input  wire logic                            hsel_i,
    input  wire logic [7:0]                      haddr_i,
    input  wire logic [1:0]                      htrans_i,
    input  wire logic                            hwrite_i,
    input  wire logic [2:0]                      hsize_i,
    input  wire logic [31:0]                     hwdata_i,
    input  wire logic                            hready_i,
    output logic      [31:0]                     hrdata_o,
    output logic                                 hreadyout_o,
    output logic                                 hresp_o
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // the settle counter is 24 bits wide
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 32'h00ff_ffff)
    begin : g_bad_settle
        $error("SETTLE_CYCLES out of range");
    end

    if (test_strap_pkg::MODE_BITS > test_strap_pkg::TP_WIDTH)
    begin : g_bad_mode_bits
        $error("MODE_BITS exceeds TP_WIDTH");
    end

    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    // board pins, no timing relation to this clock
    logic [9:0] pins_sync;

    sync_two_flop #(
        .WIDTH (10)
    ) u_sync (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .async_i  ({incircuit_float_enable_i, power_on_sense_i, test_point_port_i}),
        .sync_o   (pins_sync)
    );

    logic [7:0] strap_sync;
    logic       sense_sync;
    logic       float_sync;

    assign strap_sync = pins_sync[7:0];
    assign sense_sync = pins_sync[8];
    assign float_sync = pins_sync[9];

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------
    test_strap_pkg::seq_state_type seq_reg;
    logic [23:0]                   settle_cnt_reg;
    logic                          sense_prev_reg;
    logic                          sense_rise;

    // a rising sense edge starts a fresh capture and settle period
    assign sense_rise = sense_sync & ~sense_prev_reg; // R5

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sense_prev_reg <= 1'b0;
        else
            sense_prev_reg <= sense_sync;
    end

    // losing power sense restarts hold and the settle count
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            seq_reg        <= test_strap_pkg::SEQ_HOLD;
            settle_cnt_reg <= 24'h00_0000;
        end
        else if (!sense_sync)
        begin
            seq_reg        <= test_strap_pkg::SEQ_HOLD;
            settle_cnt_reg <= 24'h00_0000;
        end
        else
        begin
            unique case (seq_reg)
                test_strap_pkg::SEQ_HOLD:
                begin
                    if (sense_rise)
                        seq_reg <= test_strap_pkg::SEQ_SETTLE; // R15
                end
                test_strap_pkg::SEQ_SETTLE:
                begin
                    if (settle_cnt_reg == 24'(SETTLE_CYCLES - 1))
                        seq_reg <= test_strap_pkg::SEQ_RUN; // R15
                    else
                        settle_cnt_reg <= settle_cnt_reg + 24'h00_0001;
                end
                test_strap_pkg::SEQ_RUN:
                begin
                    seq_reg <= test_strap_pkg::SEQ_RUN;
                end
                default:
                begin
                    seq_reg <= test_strap_pkg::SEQ_HOLD;
                end
            endcase
        end
    end

    // hold: pads undriven, every reset low
    logic in_reset;
    assign in_reset = (seq_reg == test_strap_pkg::SEQ_HOLD);

    // ----------------------------------------------------------------
    // strap capture
    // ----------------------------------------------------------------
    // pull-downs live in the pad; a floating pin resolves to zero before it reaches here
    // late jumper moves wait for the next sense edge
    logic [7:0] strap_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            strap_reg <= test_strap_pkg::TP_RESET_VALUE; // R3
        else if (sense_rise)
            strap_reg <= strap_sync; // R2 R5
    end

    logic [3:0] mode_sel;
    assign mode_sel = strap_reg[test_strap_pkg::MODE_BITS-1:0]; // R6

    // ----------------------------------------------------------------
    // test point output mux
    // ----------------------------------------------------------------
    // undefined modes stay quiet to save switching
    logic [7:0] tp_next;

    always_comb
    begin
        tp_next = test_strap_pkg::TP_RESET_VALUE;
        unique case (mode_sel)
            test_strap_pkg::MODE_CALIBRATION:
                tp_next = {calib_i.reset_aux, calib_i.wheel_rev, calib_i.wheel_spoke,
                           calib_i.seq_index, calib_i.wheel_index_dly, calib_i.vsync}; // R7
            test_strap_pkg::MODE_CPU_DEBUG:
                tp_next = cpu_debug_bit_i; // R8
            test_strap_pkg::MODE_IDLE:
                tp_next = test_strap_pkg::TP_RESET_VALUE; // R4 R8
            default:
                tp_next = test_strap_pkg::TP_RESET_VALUE; // R16
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            test_point_port_o    <= test_strap_pkg::TP_RESET_VALUE;
            test_point_port_oe_o <= 8'h00;
        end
        else
        begin
            test_point_port_o    <= tp_next;
            // inputs while held in reset, driven once released, floated for board test
            test_point_port_oe_o <= (in_reset || float_sync) ? 8'h00 : 8'hff; // R1 R10
        end
    end

    // ----------------------------------------------------------------
    // board test float and scan outputs
    // ----------------------------------------------------------------
    // the scan cells themselves sit in the pad ring; the two scan outputs here stay driven
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            outputs_float_o   <= 1'b0;
            scan_out_one_o    <= 1'b0;
            scan_out_two_o    <= 1'b0;
            scan_out_one_oe_o <= 1'b0;
            scan_out_two_oe_o <= 1'b0;
        end
        else
        begin
            outputs_float_o   <= float_sync; // R10 R11
            scan_out_one_o    <= scan_tdo_one_i;
            scan_out_two_o    <= scan_tdo_two_i;
            scan_out_one_oe_o <= 1'b1; // R10
            scan_out_two_oe_o <= 1'b1; // R10
        end
    end

    // ----------------------------------------------------------------
    // bus write capture
    // ----------------------------------------------------------------
    logic       wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic       addr_phase;
    logic       bus_write;

    assign addr_phase = hsel_i && hready_i && htrans_i[1];
    assign bus_write  = wr_pend_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (hready_i)
        begin
            wr_pend_reg <= addr_phase && hwrite_i && (hsize_i == 3'h2);
            wr_addr_reg <= haddr_i;
        end
    end

    // ----------------------------------------------------------------
    // functional mode
    // ----------------------------------------------------------------
    // host writes are dropped while held in reset
    logic active_reg;

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            active_reg <= 1'b0;
        else if (in_reset)
            active_reg <= 1'b0;
        else if (bus_write && wr_addr_reg == test_strap_pkg::MODE_CTRL_ADDR)
            active_reg <= hwdata_i[test_strap_pkg::CTRL_ACTIVE_BIT]; // R12
    end

    // standby parks the mirrors and blanks the image
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            sys_ctrl_o <= '{pll_reset_n: 1'b0, cpu_reset_n: 1'b0, active_mode: 1'b0,
                            mirror_park: 1'b1, display_enable: 1'b0};
        else
        begin
            sys_ctrl_o.pll_reset_n    <= ~in_reset; // R15
            sys_ctrl_o.cpu_reset_n    <= (seq_reg == test_strap_pkg::SEQ_RUN); // R15 R13
            sys_ctrl_o.active_mode    <= active_reg; // R14
            sys_ctrl_o.mirror_park    <= ~active_reg; // R13
            sys_ctrl_o.display_enable <= active_reg; // R13 R14
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite slave, zero wait state
    // ----------------------------------------------------------------
    // the decode never stalls, so hreadyout is held high and responses are always okay
    // read data stands through the data phase
    logic [31:0] rd_next;

    always_comb
    begin
        rd_next = 32'h0000_0000;
        unique case (haddr_i)
            test_strap_pkg::MODE_CTRL_ADDR:
                rd_next[test_strap_pkg::CTRL_ACTIVE_BIT] = active_reg;
            test_strap_pkg::STATUS_ADDR:
            begin
                rd_next[test_strap_pkg::ST_FUNC_BIT]    = sys_ctrl_o.active_mode;
                rd_next[test_strap_pkg::ST_CPU_RUN_BIT] = sys_ctrl_o.cpu_reset_n;
                rd_next[test_strap_pkg::ST_PLL_RUN_BIT] = sys_ctrl_o.pll_reset_n;
                rd_next[test_strap_pkg::ST_FLOAT_BIT]   = outputs_float_o;
            end
            test_strap_pkg::STRAP_ADDR:
                rd_next[7:0] = strap_reg;
            default:
                rd_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
        else
        begin
            if (addr_phase && !hwrite_i)
                hrdata_o <= rd_next;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

endmodule // test_strap_ctrl

/* verification/test_strap_ctrl_assertions.sv */
// checker: concurrent assertions on the test strap and mode control ports
`timescale 1ns/1ns
module test_strap_ctrl_checker #(
    parameter int unsigned SETTLE_CYCLES = 20
)
(
    input wire logic                         mclk_i,
    input wire logic                         resetn_i,
    input wire logic [7:0]                   test_point_port_i,
    input wire logic [7:0]                   test_point_port_o,
    input wire logic [7:0]                   test_point_port_oe_o,
    input wire logic                         scan_tdo_one_i,
    input wire logic                         scan_out_one_o,
    input wire logic                         scan_out_one_oe_o,
    input wire logic                         scan_out_two_oe_o,
    input wire test_strap_pkg::calib_type    calib_i,
    input wire logic [7:0]                   cpu_debug_bit_i,
    input wire test_strap_pkg::sys_ctrl_type sys_ctrl_o,
    input wire logic                         outputs_float_o
);
    // ------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------
    logic [3:0]  mode_seen;
    logic [31:0] settle_cnt;
    logic [7:0]  calib_tp;
    logic        pll_on;
    logic        cpu_on;
    assign pll_on = sys_ctrl_o.pll_reset_n;
    assign cpu_on = sys_ctrl_o.cpu_reset_n;
    assign calib_tp = {calib_i.reset_aux, calib_i.wheel_rev, calib_i.wheel_spoke, calib_i.seq_index,
                       calib_i.wheel_index_dly, calib_i.vsync};
    // pins show the straps only while the pads are undriven, so freeze once the pll runs
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mode_seen <= 4'h0;
        else if (!pll_on)
            mode_seen <= test_point_port_i[3:0];
    end
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            settle_cnt <= 32'h0;
        else if (!pll_on)
            settle_cnt <= 32'h0;
        else if (!cpu_on)
            settle_cnt <= settle_cnt + 32'h1;
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    property p_oe_held;
        !pll_on && !$past(pll_on) |-> test_point_port_oe_o == 8'h00;
    endproperty
    a_oe_held: assert property (p_oe_held) else $error("pads driven while held");
    property p_oe_drive;
        pll_on && $past(pll_on) && !outputs_float_o && !$past(outputs_float_o) |-> test_point_port_oe_o == 8'hff;
    endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("pads not driven after release");
    property p_float;
        outputs_float_o && $past(outputs_float_o) |-> test_point_port_oe_o == 8'h00 && scan_out_one_oe_o
            && scan_out_two_oe_o;
    endproperty
    a_float: assert property (p_float) else $error("float enable mishandled");
    property p_scan;
        outputs_float_o |-> scan_out_one_o == $past(scan_tdo_one_i);
    endproperty
    a_scan: assert property (p_scan) else $error("scan data lost while floated");
    property p_calib;
        pll_on && $past(pll_on) && mode_seen == 4'h8 |-> test_point_port_o == $past(calib_tp);
    endproperty
    a_calib: assert property (p_calib) else $error("calibration set wrong");
    property p_debug;
        pll_on && $past(pll_on) && mode_seen == 4'h1 |-> test_point_port_o == $past(cpu_debug_bit_i);
    endproperty
    a_debug: assert property (p_debug) else $error("debug set wrong");
    property p_idle;
        pll_on && $past(pll_on) && mode_seen != 4'h8 && mode_seen != 4'h1 |-> test_point_port_o == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("idle outputs not low");
    property p_settle;
        $rose(cpu_on) |-> settle_cnt >= SETTLE_CYCLES - 1 && settle_cnt <= SETTLE_CYCLES + 1;
    endproperty
    a_settle: assert property (p_settle) else $error("cpu released at wrong time");
    property p_order;
        !pll_on |-> !cpu_on;
    endproperty
    a_order: assert property (p_order) else $error("cpu released before pll");
    property p_standby;
        !sys_ctrl_o.active_mode |-> sys_ctrl_o.mirror_park && !sys_ctrl_o.display_enable;
    endproperty
    a_standby: assert property (p_standby) else $error("standby shows image");
    property p_active;
        sys_ctrl_o.active_mode && $past(sys_ctrl_o.active_mode) |-> !sys_ctrl_o.mirror_park
            && sys_ctrl_o.display_enable;
    endproperty
    a_active: assert property (p_active) else $error("active mode not enabled");
endmodule // test_strap_ctrl_checker

bind test_strap_ctrl test_strap_ctrl_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) test_strap_ctrl_checker_inst (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .test_point_port_i(test_point_port_i),
    .test_point_port_o(test_point_port_o), .test_point_port_oe_o(test_point_port_oe_o),
    .scan_tdo_one_i(scan_tdo_one_i), .scan_out_one_o(scan_out_one_o), .scan_out_one_oe_o(scan_out_one_oe_o),
    .scan_out_two_oe_o(scan_out_two_oe_o), .calib_i(calib_i), .cpu_debug_bit_i(cpu_debug_bit_i),
    .sys_ctrl_o(sys_ctrl_o), .outputs_float_o(outputs_float_o));

/* verification/board_strap_model.sv */
// model: board strap jumpers and pin pull-downs facing the test point pads
`timescale 1ns/1ns
module board_strap_model
(
    // jumpers fitted on the board
    input  wire logic [7:0] strap_i,
    // pad side of the device
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_i,
    output logic      [7:0] pad_level_o
);
    // ------------------------------------------------------------
    // pin level
    // ------------------------------------------------------------
    // a released pin falls to its pull-down unless a jumper pulls it up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pad_level_o[i] = pad_oe_i[i] ? pad_out_i[i] : strap_i[i];
        end
    end
endmodule // board_strap_model

/* verification/test_strap_and_mode_control_tb.sv */
// testbench: strap capture, test point modes, board float and functional mode scenarios
`timescale 1ns/1ns
module test_strap_and_mode_control_tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int unsigned SETTLE = 20;
    logic        mclk_i, resetn_i, power_on_sense_i, incircuit_float_enable_i, hsel_i, hwrite_i;
    logic        scan_tdo_one_i, scan_tdo_two_i, scan_one, scan_two, scan_one_oe, scan_two_oe, float_o;
    logic        hreadyout, hresp;
    logic [7:0]  tp_pin, tp_out, tp_oe, strap, cpu_debug_bit_i, haddr_i;
    logic [1:0]  htrans_i;
    logic [2:0]  hsize_i;
    logic [31:0] hwdata_i, hrdata, rd;
    int          fail_count, total_checks;
    test_strap_pkg::calib_type    calib_i;
    test_strap_pkg::sys_ctrl_type sys_ctrl;

    test_strap_ctrl #(.SETTLE_CYCLES(SETTLE)) test_strap_ctrl_inst (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .power_on_sense_i(power_on_sense_i),
        .incircuit_float_enable_i(incircuit_float_enable_i), .test_point_port_i(tp_pin),
        .test_point_port_o(tp_out), .test_point_port_oe_o(tp_oe), .scan_tdo_one_i(scan_tdo_one_i),
        .scan_tdo_two_i(scan_tdo_two_i), .scan_out_one_o(scan_one), .scan_out_two_o(scan_two),
        .scan_out_one_oe_o(scan_one_oe), .scan_out_two_oe_o(scan_two_oe), .calib_i(calib_i),
        .cpu_debug_bit_i(cpu_debug_bit_i), .sys_ctrl_o(sys_ctrl), .outputs_float_o(float_o),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp));
    board_strap_model board_strap_model_inst (.strap_i(strap), .pad_out_i(tp_out), .pad_oe_i(tp_oe),
        .pad_level_o(tp_pin));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [31:0] exp_tp(input logic [3:0] m, input logic [7:0] c, input logic [7:0] d);
        if (m == test_strap_pkg::MODE_CALIBRATION)
            return {24'h0, c[2:0], c[3], c[4], c[5], c[6], c[7]};
        if (m == test_strap_pkg::MODE_CPU_DEBUG)
            return {24'h0, d};
        return 32'h0;
    endfunction
    // one single word transfer; the answer is awaited, never assumed
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr_i <= a;
        hwrite_i <= wr;
        htrans_i <= 2'h2;
        do @(posedge mclk_i); while (hreadyout !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge mclk_i); while (hreadyout !== 1'b1);
        rd = hrdata;
        check(32'(hresp), 32'h0);
    endtask
    task automatic power_up(input logic [7:0] s);
        power_on_sense_i <= 1'b0;
        strap <= s;
        repeat (6) @(posedge mclk_i);
        check(32'(tp_oe), 32'h0);
        power_on_sense_i <= 1'b1;
        do @(posedge mclk_i); while (sys_ctrl.pll_reset_n !== 1'b1);
        repeat (SETTLE - 3) @(posedge mclk_i);
        check(32'(sys_ctrl.cpu_reset_n), 32'h0);
        do @(posedge mclk_i); while (sys_ctrl.cpu_reset_n !== 1'b1);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_modes();
        for (int m = 0; m < 16; m++)
        begin
            power_up(8'(m));
            calib_i <= 8'hc5 ^ 8'(m);
            cpu_debug_bit_i <= 8'h6d ^ 8'(m);
            repeat (3) @(posedge mclk_i);
            check(32'(tp_out), exp_tp(4'(m), calib_i, cpu_debug_bit_i));
            check(32'(tp_oe), 32'hff);
            bus(1'b0, test_strap_pkg::STRAP_ADDR, 32'h0);
            check(32'(rd[7:0]), 32'(m));
        end
    endtask
    task automatic test_float();
        power_up(8'h01);
        incircuit_float_enable_i <= 1'b1;
        strap <= 8'h08;
        scan_tdo_one_i <= 1'b1;
        scan_tdo_two_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        check(32'({float_o, tp_oe, scan_one_oe, scan_two_oe, scan_one, scan_two}), 32'h100f);
        incircuit_float_enable_i <= 1'b0;
        repeat (6) @(posedge mclk_i);
        check(32'(tp_out), 32'(cpu_debug_bit_i));
        bus(1'b0, test_strap_pkg::STRAP_ADDR, 32'h0);
        check(32'(rd[7:0]), 32'h01);
        power_up(8'h08);
        repeat (3) @(posedge mclk_i);
        check(32'(tp_out), exp_tp(4'h8, calib_i, cpu_debug_bit_i));
    endtask
    task automatic test_func();
        bus(1'b1, test_strap_pkg::MODE_CTRL_ADDR, 32'h1);
        repeat (3) @(posedge mclk_i);
        check(32'(sys_ctrl), 32'h1d);
        bus(1'b0, test_strap_pkg::STATUS_ADDR, 32'h0);
        check(32'(rd[3:0]), 32'h7);
        bus(1'b1, test_strap_pkg::MODE_CTRL_ADDR, 32'h0);
        repeat (3) @(posedge mclk_i);
        check(32'(sys_ctrl), 32'h1a);
        bus(1'b0, 8'h0c, 32'h0);
        check(rd, 32'h0);
    endtask

    // ------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial
    begin
        {resetn_i, power_on_sense_i, incircuit_float_enable_i, scan_tdo_one_i, scan_tdo_two_i} = 5'h0;
        {strap, cpu_debug_bit_i, calib_i, haddr_i, htrans_i, hwrite_i, hwdata_i} = 67'h0;
        hsel_i = 1'b1;
        hsize_i = 3'h2;
        fail_count = 0;
        total_checks = 0;
        repeat (5) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        test_modes();
        test_float();
        test_func();
        conclude();
    end
    // the scenarios need about seven hundred cycles
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        conclude();
    end
endmodule // test_strap_and_mode_control_tb
